// >>> s2nf_pkg.sv
// constants, configuration carrier and output carrier for the serial-to-network framer
// assumes a single 250 MHz sys_clk; configuration ports are held steady by firmware
// Notes on behaviour
// - close frame after idle interval, counted in 10 ms units, reset value zero
// - idle interval zero means two character times at the current baud rate
// - continuous serial data is cut at the maximum network packet size
// - with separator framing on, end the packet when the separator is seen
// - with separator framing on, no packet exceeds 512 bytes
// - separator length selectable 0..4 characters, compared in order
// - after a separator, end there or after one or two further bytes
// - at most eight simultaneous host sessions in fan-out mode
// - bytes from any connected host go to the serial device
// - every serial frame is copied to all connected sessions except those still waiting for their address announcement
// - optional hardware-address announcement first on every new connection; a frame byte moved in the connect cycle reaches the session before it
// - outgoing segments wait about 40 ms unless segment_delay_off is set
// - full-duplex differential mode keeps the line driver always on
// - combined passive/active mode only allowed as connection client
// - dynamic DNS address report uses fixed refresh value 40,320
// - TCP/UDP address report sends ASCII or hex at a set interval
package s2nf_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_10MS_NS = 10_000_000;
    localparam int CYC_10MS = T_10MS_NS / CLK_PERIOD_NS;
    localparam int T_SEG_DELAY_NS = 40_000_000;
    localparam int CYC_SEG_DELAY = T_SEG_DELAY_NS / CLK_PERIOD_NS;
    localparam logic [7:0] IDLE_INTERVAL_RESET = 8'h00;
    localparam logic [9:0] SEP_PKT_MAX = 10'h200;
    localparam int SEP_MAX_LEN = 4;
    localparam int HW_ADDR_BYTES = 6;
    localparam int SESSIONS = 8;
    localparam logic [15:0] DDNS_REFRESH = 16'h9d80;

    typedef enum logic [1:0] {S2NF_SEP_ONLY = 2'h0, S2NF_SEP_PLUS1 = 2'h1,
        S2NF_SEP_PLUS2 = 2'h2} s2nf_sep_op_t;
    typedef enum logic [1:0] {S2NF_RPT_OFF = 2'h0, S2NF_RPT_DDNS = 2'h1,
        S2NF_RPT_TCP = 2'h2, S2NF_RPT_UDP = 2'h3} s2nf_rpt_t;
    typedef enum logic [1:0] {S2NF_ANN_IDLE = 2'b01, S2NF_ANN_SEND = 2'b10} s2nf_ann_t;

    typedef struct packed {
        logic [7:0] idle_interval;
        logic [15:0] char_cycles;
        logic [9:0] max_pkt;
        logic [2:0] sep_len;
        s2nf_sep_op_t sep_op;
        logic [3:0][7:0] sep_chars;
        logic segment_delay_off;
        logic announce_hw_id;
        logic multi_conn;
        logic full_duplex;
        logic conn_client;
        logic combo_req;
        s2nf_rpt_t address_change_report;
        logic report_ascii;
        logic [15:0] report_interval;
    } s2nf_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic [SESSIONS-1:0] dest;
    } s2nf_net_byte_t;
endpackage

// >>> s2nf_framer.sv
// serial-to-network framer: frames serial bytes, fans frames out to sessions,
// announces the hardware address, merges host data to serial, times address reports
// assumes serial bytes and network bytes arrive from logic on sys_clk (no crossing)
`timescale 1ns/10ps
module s2nf_framer
    import s2nf_pkg::*;
#(
    parameter int TICK_CYC = CYC_10MS,
    parameter int SEG_DLY_CYC = CYC_SEG_DELAY
)(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire s2nf_cfg_t cfg,
    input wire logic [47:0] hw_addr,
    input wire logic ser_rx_valid,
    input wire logic [7:0] ser_rx_data,
    output logic ser_rx_ready,
    output logic net_tx_valid,
    output s2nf_net_byte_t net_tx,
    input wire logic net_tx_ready,
    output logic seg_push,
    input wire logic [SESSIONS-1:0] session_up,
    input wire logic net_rx_valid,
    input wire logic [7:0] net_rx_data,
    input wire logic [2:0] net_rx_session,
    output logic net_rx_ready,
    output logic ser_tx_valid,
    output logic [7:0] ser_tx_data,
    input wire logic ser_tx_ready,
    input wire logic ser_tx_busy,
    output logic drv_en,
    output logic combo_mode,
    output logic report_req,
    output logic report_ascii,
    output logic [15:0] report_refresh
);
    function automatic logic sep_hit(input logic [3:0][7:0] win, input logic [3:0][7:0] sep,
        input logic [2:0] len);
        logic ok;
        ok = (len != 3'h0) && (len <= 3'h4);
        for (int i = 0; i < SEP_MAX_LEN; i++)
        begin
            if (i < int'(len) && win[int'(len) - 1 - i] != sep[i])
                ok = 1'b0;
        end
        return ok;
    endfunction

    logic [SESSIONS-1:0] conn;
    logic [SESSIONS-1:0] conn_prev;
    logic [SESSIONS-1:0] ann_pend;
    logic [SESSIONS-1:0] ann_dest;
    logic [2:0] ann_idx;
    s2nf_ann_t ann_state;
    logic hold_v;
    logic [7:0] hold_data;
    logic hold_last;
    logic [2:0][7:0] hist;
    logic [9:0] frame_cnt;
    logic [1:0] tail_cnt;
    logic tail_on;
    logic [31:0] idle_cnt;
    logic [31:0] idle_limit;
    logic idle_fire;
    logic out_free;
    logic hold_move;
    logic accept;
    logic cut;
    logic [3:0][7:0] win;
    logic [9:0] pkt_limit;
    logic [SESSIONS-1:0] ann_next;
    logic flush_pend;
    logic [31:0] seg_cnt;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] rpt_cnt;
    logic [15:0] rpt_limit;

    // a single-session setup only ever talks to session 0
    assign conn = cfg.multi_conn ? session_up : {{(SESSIONS-1){1'b0}}, session_up[0]};
    assign out_free = !net_tx_valid || net_tx_ready;

    // zero interval falls back to two character times at the current baud rate
    assign idle_limit = (cfg.idle_interval == IDLE_INTERVAL_RESET)
        ? {15'h0000, cfg.char_cycles, 1'b0}
        : 32'(cfg.idle_interval) * 32'(TICK_CYC);

    assign idle_fire = hold_v && !hold_last && (idle_cnt >= idle_limit);
    assign hold_move = hold_v && out_free && (ann_state == S2NF_ANN_IDLE)
        && (hold_last || idle_fire || ser_rx_valid);
    // a byte never joins a frame that the idle timer closes in the same cycle
    assign ser_rx_ready = !hold_v || (hold_move && !idle_fire);
    assign accept = ser_rx_valid && ser_rx_ready;
    assign win = {hist, ser_rx_data};
    assign pkt_limit = (cfg.sep_len != 3'h0 && cfg.max_pkt > SEP_PKT_MAX) ? SEP_PKT_MAX
        : cfg.max_pkt;

    always_comb
    begin
        cut = (frame_cnt + 10'h001 >= pkt_limit);
        if (tail_on)
            cut = cut || (tail_cnt == 2'h1);
        else if (sep_hit(win, cfg.sep_chars, cfg.sep_len) && cfg.sep_op == S2NF_SEP_ONLY)
            cut = 1'b1;
    end

    // serial byte holding stage: the byte waits until its frame position is known
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hold_v <= 1'b0;
            hold_data <= 8'h00;
            hold_last <= 1'b0;
        end
        else if (accept)
        begin
            hold_v <= 1'b1;
            hold_data <= ser_rx_data;
            hold_last <= cut;
        end
        else if (hold_move)
        begin
            hold_v <= 1'b0;
            hold_last <= 1'b0;
        end
    end

    // frame bookkeeping: length, separator history and trailing byte count
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            frame_cnt <= 10'h000;
            hist <= '0;
            tail_cnt <= 2'h0;
            tail_on <= 1'b0;
        end
        else if ((accept && cut) || (hold_move && idle_fire))
        begin
            frame_cnt <= 10'h000;
            hist <= '0;
            tail_on <= 1'b0;
            tail_cnt <= 2'h0;
        end
        else if (accept)
        begin
            frame_cnt <= frame_cnt + 10'h001;
            hist <= win[2:0];
            if (tail_on)
                tail_cnt <= tail_cnt - 2'h1;
            else if (sep_hit(win, cfg.sep_chars, cfg.sep_len))
            begin
                tail_on <= 1'b1;
                tail_cnt <= cfg.sep_op;
            end
        end
    end

    // idle timer restarts on every byte and only matters while a byte is pending
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            idle_cnt <= 32'h0000_0000;
        else if (accept || !hold_v)
            idle_cnt <= 32'h0000_0000;
        else if (idle_cnt != 32'hffff_ffff)
            idle_cnt <= idle_cnt + 32'h0000_0001;
    end

    // new connections queue an announcement; the set wins over the clear
    assign ann_next = conn & ~conn_prev & {SESSIONS{cfg.announce_hw_id}};
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            conn_prev <= '0;
            ann_pend <= '0;
        end
        else
        begin
            conn_prev <= conn;
            ann_pend <= ((ann_state == S2NF_ANN_SEND && out_free && ann_idx == 3'h5)
                ? (ann_pend & ~ann_dest) : ann_pend) & conn | ann_next;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ann_state <= S2NF_ANN_IDLE;
            ann_dest <= '0;
            ann_idx <= 3'h0;
        end
        else
        begin
            unique case (ann_state)
                S2NF_ANN_IDLE:
                begin
                    ann_idx <= 3'h0;
                    if (ann_pend != '0 && !hold_move)
                    begin
                        ann_dest <= ann_pend & (~ann_pend + 8'h01);
                        ann_state <= S2NF_ANN_SEND;
                    end
                end
                S2NF_ANN_SEND:
                begin
                    if (out_free)
                    begin
                        ann_idx <= ann_idx + 3'h1;
                        if (ann_idx == 3'h5)
                            ann_state <= S2NF_ANN_IDLE;
                    end
                end
            endcase
        end
    end

    // output byte register; frame data skips sessions queued in ann_pend, which a new session joins only a cycle after it connects
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            net_tx_valid <= 1'b0;
            net_tx <= '0;
        end
        else if (ann_state == S2NF_ANN_SEND && out_free)
        begin
            net_tx_valid <= 1'b1;
            net_tx.data <= hw_addr[8'(47 - 8 * int'(ann_idx)) -: 8];
            net_tx.last <= (ann_idx == 3'h5);
            net_tx.dest <= ann_dest;
        end
        else if (hold_move)
        begin
            net_tx_valid <= 1'b1;
            net_tx.data <= hold_data;
            net_tx.last <= hold_last || idle_fire;
            net_tx.dest <= conn & ~ann_pend;
        end
        else if (net_tx_ready)
            net_tx_valid <= 1'b0;
    end

    // coalescing delay: frames ending within 40 ms of the first share one push
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flush_pend <= 1'b0;
            seg_cnt <= 32'h0000_0000;
            seg_push <= 1'b0;
        end
        else
        begin
            seg_push <= 1'b0;
            if (net_tx_valid && net_tx_ready && net_tx.last && cfg.segment_delay_off)
                seg_push <= 1'b1;
            else if (flush_pend && seg_cnt >= 32'(SEG_DLY_CYC - 1))
            begin
                seg_push <= 1'b1;
                flush_pend <= 1'b0;
                seg_cnt <= 32'h0000_0000;
            end
            else if (flush_pend)
                seg_cnt <= seg_cnt + 32'h0000_0001;
            else if (net_tx_valid && net_tx_ready && net_tx.last)
                flush_pend <= 1'b1;
        end
    end

    // host bytes to serial; bytes from an unconnected session are dropped
    assign net_rx_ready = !ser_tx_valid || ser_tx_ready;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ser_tx_valid <= 1'b0;
            ser_tx_data <= 8'h00;
        end
        else if (net_rx_valid && net_rx_ready && conn[net_rx_session])
        begin
            ser_tx_valid <= 1'b1;
            ser_tx_data <= net_rx_data;
        end
        else if (ser_tx_ready)
            ser_tx_valid <= 1'b0;
    end

    // full duplex cannot share the line, so it never releases the driver
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            drv_en <= 1'b0;
            combo_mode <= 1'b0;
        end
        else
        begin
            drv_en <= cfg.full_duplex || ser_tx_busy || ser_tx_valid;
            combo_mode <= cfg.combo_req && cfg.conn_client;
        end
    end

    // address report timer in 10 ms ticks; dynamic DNS ignores the set interval
    assign rpt_limit = (cfg.address_change_report == S2NF_RPT_DDNS) ? DDNS_REFRESH
        : cfg.report_interval;
    assign tick = (tick_cnt >= 32'(TICK_CYC - 1));

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_cnt <= 32'h0000_0000;
            rpt_cnt <= 16'h0000;
            report_req <= 1'b0;
            report_ascii <= 1'b0;
            report_refresh <= 16'h0000;
        end
        else
        begin
            tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
            report_refresh <= rpt_limit;
            report_ascii <= cfg.report_ascii;
            report_req <= 1'b0;
            if (cfg.address_change_report == S2NF_RPT_OFF || rpt_limit == 16'h0000)
                rpt_cnt <= 16'h0000;
            else if (tick && rpt_cnt + 16'h0001 >= rpt_limit)
            begin
                rpt_cnt <= 16'h0000;
                report_req <= 1'b1;
            end
            else if (tick)
                rpt_cnt <= rpt_cnt + 16'h0001;
        end
    end
endmodule

// >>> s2nf_sva.sv
// port assertions for the framer, bound into every instance
// assumes cfg changes only between transfers
`timescale 1ns/10ps
module s2nf_sva
    import s2nf_pkg::*;
#(
    parameter int TICK_CYC = CYC_10MS,
    parameter int SEG_DLY_CYC = CYC_SEG_DELAY
)(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire s2nf_cfg_t cfg,
    input wire logic net_tx_valid,
    input wire s2nf_net_byte_t net_tx,
    input wire logic net_tx_ready,
    input wire logic seg_push,
    input wire logic [SESSIONS-1:0] session_up,
    input wire logic net_rx_valid,
    input wire logic [7:0] net_rx_data,
    input wire logic [2:0] net_rx_session,
    input wire logic net_rx_ready,
    input wire logic ser_tx_valid,
    input wire logic [7:0] ser_tx_data,
    input wire logic ser_tx_ready,
    input wire logic drv_en,
    input wire logic combo_mode,
    input wire logic [15:0] report_refresh
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [9:0] cnt;
    logic pend;
    wire acc = net_tx_valid & net_tx_ready;
    // announcement bytes interleave with frames, so counts are only trusted without them
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cnt <= 10'h000;
        else if (acc)
            cnt <= net_tx.last ? 10'h000 : cnt + 10'h001;
    end
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            pend <= 1'b0;
        else if (acc && net_tx.last)
            pend <= 1'b1;
        else if (seg_push)
            pend <= 1'b0;
    end
    sequence s_host_take;
        net_rx_valid && net_rx_ready && session_up[net_rx_session] && cfg.multi_conn;
    endsequence
    sequence s_last_fresh;
        acc && net_tx.last && !pend;
    endsequence
    a_pkt_max: assert property (acc && !cfg.announce_hw_id |-> cnt < cfg.max_pkt)
        else $error("frame longer than max_pkt");
    a_sep_cap: assert property (acc && cfg.sep_len != 3'h0 && !cfg.announce_hw_id
        |-> cnt < SEP_PKT_MAX) else $error("separator frame over 512");
    a_seg_fast: assert property (acc && net_tx.last && cfg.segment_delay_off |=> seg_push)
        else $error("segment not pushed at once");
    a_seg_slow: assert property (s_last_fresh and !cfg.segment_delay_off
        |=> !seg_push [*8]) else $error("segment pushed without delay");
    a_host_fwd: assert property (s_host_take
        |=> ser_tx_valid && ser_tx_data == $past(net_rx_data))
        else $error("host byte not forwarded");
    a_ser_hold: assert property (ser_tx_valid && !ser_tx_ready
        |=> ser_tx_valid && $stable(ser_tx_data))
        else $error("serial byte dropped before ready");
    a_tx_hold: assert property (net_tx_valid && !net_tx_ready
        |=> net_tx_valid && $stable(net_tx))
        else $error("network byte changed before ready");
    a_drv_on: assert property (cfg.full_duplex |=> drv_en)
        else $error("driver off in full duplex");
    a_combo_cli: assert property (combo_mode |-> $past(cfg.conn_client))
        else $error("combined mode without client");
    a_ddns_fix: assert property (cfg.address_change_report == S2NF_RPT_DDNS
        |=> report_refresh == 16'h9d80) else $error("refresh value not fixed");
endmodule
bind s2nf_framer s2nf_sva #(.TICK_CYC(TICK_CYC), .SEG_DLY_CYC(SEG_DLY_CYC)) u_sva (
    .sys_clk, .resetn, .cfg, .net_tx_valid, .net_tx, .net_tx_ready, .seg_push, .session_up,
    .net_rx_valid, .net_rx_data, .net_rx_session, .net_rx_ready, .ser_tx_valid, .ser_tx_data,
    .ser_tx_ready, .drv_en, .combo_mode, .report_refresh);

// >>> s2nf_net_host.sv
// network host model: takes framed bytes, may stall, flags each byte taken
// assumes the framer's sys_clk; ready moves only on the rising edge
`timescale 1ns/10ps
module s2nf_net_host
    import s2nf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic net_tx_valid,
    input wire s2nf_net_byte_t net_tx,
    output logic net_tx_ready,
    output logic got,
    output s2nf_net_byte_t seen
);
    // a slow host toggles ready so held bytes must stand across stalls
    initial
    begin
        net_tx_ready = 1'b1;
        forever
        begin
            @(posedge sys_clk);
            net_tx_ready <= slow ? ~net_tx_ready : 1'b1;
        end
    end
    assign got = net_tx_valid & net_tx_ready;
    assign seen = net_tx;
endmodule

// >>> s2nf_tb.sv
// self-checking bench for the framer with a stalling network host
// assumes shortened ticks: TICK_CYC 10, SEG_DLY_CYC 40
`timescale 1ns/10ps
module testbench;
    import s2nf_pkg::*;
    typedef struct packed {logic [2:0] sl; logic [1:0] op; logic [9:0] exp;} s2nf_row_t;
    s2nf_row_t rows [7] = '{'{3'h0, 2'h0, 10'h8}, '{3'h1, 2'h0, 10'h2}, '{3'h2, 2'h1, 10'h4},
        '{3'h3, 2'h2, 10'h6}, '{3'h4, 2'h0, 10'h5}, '{3'h4, 2'h1, 10'h6}, '{3'h4, 2'h2, 10'h7}};
    logic [7:0] pat [8] = '{8'h55, 8'h01, 8'h02, 8'h03, 8'h04, 8'h66, 8'h77, 8'h88};
    logic sys_clk = 1'b0, resetn = 1'b0, slow = 1'b0;
    s2nf_cfg_t cfg = '0;
    logic [47:0] hw_addr = 48'h0a1b2c3d4e5f;
    logic ser_rx_valid = 1'b0, net_rx_valid = 1'b0, ser_tx_ready = 1'b1, ser_tx_busy = 1'b0;
    logic [7:0] ser_rx_data = 8'h00, net_rx_data = 8'h00;
    logic [2:0] net_rx_session = 3'h0;
    logic [SESSIONS-1:0] session_up = 8'h05;
    logic ser_rx_ready, net_tx_valid, net_tx_ready, seg_push, net_rx_ready, ser_tx_valid;
    logic drv_en, combo_mode, report_req, report_ascii, got;
    logic [7:0] ser_tx_data;
    logic [15:0] report_refresh;
    s2nf_net_byte_t net_tx, seen;
    s2nf_net_byte_t q[$];
    int failures = 0, checks_done = 0, cyc = 0, t_last = 0, t_push = 0, n_req = 0;
    s2nf_framer #(.TICK_CYC(10), .SEG_DLY_CYC(40)) u_s2nf_framer (.sys_clk, .resetn, .cfg,
        .hw_addr, .ser_rx_valid, .ser_rx_data, .ser_rx_ready, .net_tx_valid, .net_tx,
        .net_tx_ready, .seg_push, .session_up, .net_rx_valid, .net_rx_data, .net_rx_session,
        .net_rx_ready, .ser_tx_valid, .ser_tx_data, .ser_tx_ready, .ser_tx_busy, .drv_en,
        .combo_mode, .report_req, .report_ascii, .report_refresh);
    s2nf_net_host u_s2nf_net_host (.sys_clk, .slow, .net_tx_valid, .net_tx, .net_tx_ready,
        .got, .seen);
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if (got === 1'b1)
            q.push_back(seen);
        if (got === 1'b1 && seen.last === 1'b1)
            t_last = cyc;
        if (seg_push === 1'b1)
            t_push = cyc;
        if (report_req === 1'b1)
            n_req++;
    end
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s exp %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // valid stays high between calls so bytes go back to back
    task automatic put(input logic [7:0] b);
        int k;
        ser_rx_data = b;
        ser_rx_valid = 1'b1;
        for (k = 0; k < 200 && ser_rx_ready !== 1'b1; k++)
            tick(1);
        tick(1);
    endtask
    task automatic stream(input int n, input int w);
        q.delete();
        for (int i = 0; i < n; i++)
            put(i < 8 ? pat[i] : 8'haa);
        ser_rx_valid = 1'b0;
        tick(w);
    endtask
    task automatic host(input logic [7:0] b, input logic [2:0] s);
        int k;
        net_rx_data = b;
        net_rx_session = s;
        net_rx_valid = 1'b1;
        for (k = 0; k < 200 && net_rx_ready !== 1'b1; k++)
            tick(1);
        tick(1);
        net_rx_valid = 1'b0;
        tick(3);
    endtask
    function automatic logic [31:0] first_last();
        foreach (q[i])
            if (q[i].last === 1'b1)
                return 32'(i + 1);
        return 32'h0;
    endfunction
    initial
    begin
        repeat (3) @(posedge sys_clk);
        check("rst_out", 32'({net_tx_valid, ser_rx_ready, drv_en}), 32'h2);
        #1 resetn = 1'b1;
        tick(1);
        $display("reset test done");
        cfg.max_pkt = 10'h3ff;
        cfg.idle_interval = 8'h01;
        cfg.multi_conn = 1'b1;
        cfg.segment_delay_off = 1'b1;
        cfg.sep_chars = 32'h04030201;
        foreach (rows[r])
        begin
            cfg.sep_len = rows[r].sl;
            cfg.sep_op = s2nf_sep_op_t'(rows[r].op);
            stream(8, 60);
            check("first_frame", first_last(), 32'(rows[r].exp));
            check("bytes", 32'(q.size()), 32'h8);
            check("tail_last", 32'(q[7].last), 32'h1);
            check("dest", 32'(q[0].dest), 32'h5);
            $display("row %0d done", r);
        end
        cfg.sep_len = 3'h0;
        cfg.idle_interval = 8'h00;
        cfg.char_cycles = 16'h0014;
        q.delete();
        tick(60);
        check("no_pending", 32'(q.size()), 32'h0);
        put(8'h3c);
        ser_rx_valid = 1'b0;
        tick(30);
        check("early_close", 32'(q.size()), 32'h0);
        tick(30);
        check("two_char", 32'(q.size() == 1 && q[0].last === 1'b1), 32'h1);
        $display("idle test done");
        cfg.idle_interval = 8'h01;
        cfg.max_pkt = 10'h003;
        stream(8, 60);
        check("pkt_cut", first_last(), 32'h3);
        cfg.max_pkt = 10'h3ff;
        cfg.sep_len = 3'h1;
        cfg.sep_chars = 32'h000000ee;
        slow = 1'b1;
        stream(520, 80);
        check("sep_cap", first_last(), 32'h200);
        slow = 1'b0;
        $display("size test done");
        cfg.sep_len = 3'h0;
        cfg.announce_hw_id = 1'b1;
        q.delete();
        session_up = 8'h07;
        tick(40);
        check("ann_len", 32'(q.size()), 32'h6);
        check("ann_first", 32'(q[0].data), 32'h0a);
        check("ann_dest", 32'(q[0].dest), 32'h2);
        check("ann_last", 32'(q[5].last), 32'h1);
        cfg.announce_hw_id = 1'b0;
        cfg.segment_delay_off = 1'b0;
        stream(1, 80);
        check("seg_delay", 32'(t_push - t_last >= 39 && t_push - t_last <= 41), 32'h1);
        cfg.segment_delay_off = 1'b1;
        $display("network test done");
        ser_tx_ready = 1'b0;
        host(8'h5a, 3'h2);
        check("host_hold", 32'({ser_tx_valid, ser_tx_data}), 32'h15a);
        ser_tx_ready = 1'b1;
        tick(2);
        host(8'h33, 3'h4);
        check("host_drop", 32'(ser_tx_valid), 32'h0);
        check("drv_off", 32'(drv_en), 32'h0);
        cfg.full_duplex = 1'b1;
        cfg.combo_req = 1'b1;
        cfg.address_change_report = S2NF_RPT_DDNS;
        tick(2);
        check("drv_on", 32'(drv_en), 32'h1);
        check("combo_srv", 32'(combo_mode), 32'h0);
        check("ddns_ref", 32'(report_refresh), 32'h9d80);
        check("rpt_hex", 32'(report_ascii), 32'h0);
        cfg.conn_client = 1'b1;
        cfg.address_change_report = S2NF_RPT_UDP;
        cfg.report_interval = 16'h0003;
        cfg.report_ascii = 1'b1;
        n_req = 0;
        tick(100);
        check("combo_cli", 32'(combo_mode), 32'h1);
        check("rpt_count", 32'(n_req >= 2 && n_req <= 4), 32'h1);
        check("rpt_ascii", 32'(report_ascii), 32'h1);
        $display("misc test done");
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule
